/* design/bho_ctrl.sv */
`timescale 1ns/1ps

// Operation
// - feedback pull-up short/24.9k/49.9k/open picks 3.3V/5V/12V/external divider
// - setpoint stays latched until lockout recurs, then resampled on release
// - on-time demand below 50 ns selects pulse skipping
// - internal compensation only when 100k pull-up detected, else external
// - compensation choice held latched until bias lockout recurs
// - sense comparator trip ends the high-side pulse at once
// - soft-start clamp enabled only after sixteen overcurrent events
// - overload runs 512 cycle-limited cycles before hiccup
// - four clean consecutive cycles reset the overload counter
// - overload expiry pulls soft start low, gates off, starts 16384 wait
// - after 16384 cycles soft start released and switching restarts
// - hiccup suppressed in soft start until feedback exceeds 0.4 V
module bho_ctrl
    import bho_pkg::*;
#(
    parameter int HICCUP_WAIT = HICCUP_CYCLES,
    parameter int OVL_LIMIT = OVL_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CYCLE_START,
    input wire logic PWM_REQ,
    input wire logic [15:0] TON_REQ_CYC,
    input wire logic CURRENT_SENSE_POS_TRIP,
    input wire logic FEEDBACK_SENSE_ABOVE_0V4,
    input wire logic [1:0] FB_RDET,
    input wire logic COMP_SELECT_PIN_PULLUP,
    output logic HIGH_SIDE_GATE_OUT,
    output logic LOW_SIDE_GATE_OUT,
    output logic SS_PULL_LOW,
    output logic SS_CLAMP_EN,
    output logic PULSE_SKIP,
    output logic [1:0] VOUT_SEL,
    output logic INT_COMP,
    output logic IRQ,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O
);

    // ****************************************
    // configuration latch
    // ****************************************
    bho_cfg_t cfg;
    logic cfg_valid;

    bho_cfg_latch u_cfg (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .fb_rdet(FB_RDET),
        .comp_pullup_det(COMP_SELECT_PIN_PULLUP),
        .cfg(cfg),
        .cfg_valid(cfg_valid)
    );

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {ST_SOFTSTART, ST_RUN, ST_HICCUP} bho_state_t;

    bho_state_t state_q, state_d;
    logic en_q;
    logic oc_cycle_q;
    logic [2:0] clean_q;
    logic [4:0] oc_events_q;
    logic overload_q;
    logic ho_q, lo_q, skip_q;
    logic ss_low_q, clamp_q;
    logic [IRQ_W-1:0] irq_q, mask_q;
    logic irq_out_q;
    logic [31:0] dat_q;
    logic ack_q;

    // ****************************************
    // cycle bookkeeping
    // ****************************************
    wire cycle_end = CYCLE_START;
    // trip latched over the whole period, sampled once at its end
    wire oc_this = oc_cycle_q | CURRENT_SENSE_POS_TRIP;
    wire clean_done = (clean_q == 3'(CLEAN_CYCLES - 1)) && !oc_this;
    wire armed = (state_q == ST_RUN);
    wire ovl_done, hic_done;
    wire ovl_clr = !armed || (cycle_end && clean_done);
    wire ovl_inc = cycle_end && oc_this && overload_q;
    wire hic_inc = cycle_end && (state_q == ST_HICCUP);
    wire hic_clr = (state_q != ST_HICCUP);
    wire skip_d = (TON_REQ_CYC < 16'(TON_MIN_CYC));

    bho_cnt #(.LIMIT(OVL_LIMIT)) u_ovl (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .clr(ovl_clr),
        .inc(ovl_inc),
        .done(ovl_done)
    );

    bho_cnt #(.LIMIT(HICCUP_WAIT)) u_hic (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .clr(hic_clr),
        .inc(hic_inc),
        .done(hic_done)
    );

    // ****************************************
    // protection sequence
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_SOFTSTART:
                if (FEEDBACK_SENSE_ABOVE_0V4)
                    state_d = ST_RUN;
            ST_RUN:
                if (ovl_done)
                    state_d = ST_HICCUP;
            ST_HICCUP:
                if (hic_done)
                    state_d = ST_SOFTSTART;
            default:
                state_d = ST_SOFTSTART;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            state_q <= ST_SOFTSTART;
        else
            state_q <= state_d;
    end

    // per-period trip flag and clean-run count
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            oc_cycle_q <= 1'b0;
            clean_q <= '0;
            overload_q <= 1'b0;
        end
        else if (cycle_end)
        begin
            oc_cycle_q <= 1'b0;
            clean_q <= (oc_this || clean_done) ? 3'h0 : clean_q + 3'h1;
            overload_q <= armed && (oc_this || (overload_q && !clean_done));
        end
        else
            oc_cycle_q <= oc_this;
    end

    // overcurrent events toward the clamp; cleared with the overload
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || ovl_clr)
            oc_events_q <= '0;
        else if (cycle_end && oc_this && oc_events_q != 5'(CLAMP_EVENTS))
            oc_events_q <= oc_events_q + 5'h1;
    end

    // ****************************************
    // gate drive
    // ****************************************
    // gates only leave off with a valid config and outside hiccup
    wire run_ok = en_q && cfg_valid && (state_q != ST_HICCUP);
    wire ho_d = run_ok && !skip_d && PWM_REQ && !CURRENT_SENSE_POS_TRIP;

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            ho_q <= 1'b0;
            lo_q <= 1'b0;
            skip_q <= 1'b0;
            ss_low_q <= 1'b1;
            clamp_q <= 1'b0;
        end
        else
        begin
            ho_q <= ho_d;
            lo_q <= run_ok && !ho_d && !ho_q; // one dead cycle after high side
            skip_q <= skip_d;
            ss_low_q <= !run_ok;
            clamp_q <= (oc_events_q == 5'(CLAMP_EVENTS));
        end
    end

    // ****************************************
    // wishbone slave, one wait state
    // ****************************************
    wire wb_req = WB_CYC_I && WB_STB_I && !ack_q;
    wire wr_ctrl = wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADDR_CTRL;
    wire wr_mask = wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADDR_MASK;
    wire rd_irq = wb_req && !WB_WE_I && WB_ADR_I == ADDR_IRQ;
    wire [IRQ_W-1:0] ev = {cycle_end && skip_d,
                           state_q == ST_RUN && state_d == ST_HICCUP,
                           cycle_end && oc_this};

    wire [31:0] rd_mux =
        (WB_ADR_I == ADDR_CTRL) ? {31'h0000_0000, en_q} :
        (WB_ADR_I == ADDR_STAT) ? {26'h000_0000, clamp_q, skip_q, overload_q, cfg_valid, state_q} :
        (WB_ADR_I == ADDR_IRQ) ? {29'h0000_0000, irq_q} :
        (WB_ADR_I == ADDR_MASK) ? {29'h0000_0000, mask_q} :
        (WB_ADR_I == ADDR_CFG) ? {29'h0000_0000, cfg.int_comp, cfg.vout_sel} : 32'h0000_0000;

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            ack_q <= 1'b0;
            dat_q <= '0;
            en_q <= CTRL_RESET[CTRL_EN_BIT];
            mask_q <= '0;
        end
        else
        begin
            ack_q <= wb_req;
            dat_q <= wb_req && !WB_WE_I ? rd_mux : 32'h0000_0000;
            if (wr_ctrl)
                en_q <= WB_DAT_I[CTRL_EN_BIT];
            if (wr_mask)
                mask_q <= WB_DAT_I[IRQ_W-1:0];
        end
    end

    // sticky events; a new event beats the read clear
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            irq_q <= '0;
            irq_out_q <= 1'b0;
        end
        else
        begin
            irq_q <= (rd_irq ? '0 : irq_q) | ev;
            irq_out_q <= |(((rd_irq ? '0 : irq_q) | ev) & mask_q);
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign HIGH_SIDE_GATE_OUT = ho_q;
    assign LOW_SIDE_GATE_OUT = lo_q;
    assign SS_PULL_LOW = ss_low_q;
    assign SS_CLAMP_EN = clamp_q;
    assign PULSE_SKIP = skip_q;
    assign VOUT_SEL = cfg.vout_sel;
    assign INT_COMP = cfg.int_comp;
    assign IRQ = irq_out_q;
    assign WB_DAT_O = dat_q;
    assign WB_ACK_O = ack_q;

endmodule

/* design/bho_pkg.sv */
package bho_pkg;

    // ****************************************
    // setpoint and compensation encodings
    // ****************************************
    typedef enum logic [1:0] {BHO_VOUT_3V3, BHO_VOUT_5V, BHO_VOUT_12V, BHO_VOUT_EXT} bho_vout_t;

    // resistance detector codes for the feedback pull-up
    localparam logic [1:0] RDET_SHORT = 2'h0;
    localparam logic [1:0] RDET_24K9 = 2'h1;
    localparam logic [1:0] RDET_49K9 = 2'h2;
    localparam logic [1:0] RDET_OPEN = 2'h3;

    // latched configuration, carried together
    typedef struct packed {
        bho_vout_t vout_sel;
        logic int_comp;
    } bho_cfg_t;

    localparam bho_cfg_t CFG_RESET = '{vout_sel: BHO_VOUT_EXT, int_comp: 1'b0};

    // ****************************************
    // timing; minimum on-time in clock cycles, protection counts in switching cycles
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int TON_MIN_NS = 50;
    // least time rounds up to whole cycles
    localparam int TON_MIN_CYC = (TON_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int OVL_CYCLES = 512;
    localparam int HICCUP_CYCLES = 16384;
    localparam int CLEAN_CYCLES = 4;
    localparam int CLAMP_EVENTS = 16;

    // ****************************************
    // register map (word aligned byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CFG = 8'h10;

    // ctrl field positions
    localparam int CTRL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // irq/mask field positions
    localparam int IRQ_OC_BIT = 0;
    localparam int IRQ_HIC_BIT = 1;
    localparam int IRQ_SKIP_BIT = 2;
    localparam int IRQ_W = 3;

    // wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } bho_wb_req_t;

endpackage

/* design/bho_cfg_latch.sv */
`timescale 1ns/1ps

// ****************************************
// power-up configuration latch
// ****************************************
module bho_cfg_latch
    import bho_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] fb_rdet,
    input wire logic comp_pullup_det,
    output bho_cfg_t cfg,
    output logic cfg_valid
);

    bho_cfg_t cfg_q;
    logic done_q;
    bho_vout_t vout_d;

    // resistor decode of the feedback pull-up
    assign vout_d = (fb_rdet == RDET_SHORT) ? BHO_VOUT_3V3 :
                    (fb_rdet == RDET_24K9) ? BHO_VOUT_5V :
                    (fb_rdet == RDET_49K9) ? BHO_VOUT_12V : BHO_VOUT_EXT;

    // sample once after lockout release; only a new lockout re-arms
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_q <= CFG_RESET;
            done_q <= 1'b0;
        end
        else if (!done_q)
        begin
            cfg_q <= '{vout_sel: vout_d, int_comp: comp_pullup_det};
            done_q <= 1'b1;
        end
    end

    assign cfg = cfg_q;
    assign cfg_valid = done_q;

endmodule

/* design/bho_cnt.sv */
`timescale 1ns/1ps

// ****************************************
// saturating cycle counter
// ****************************************
module bho_cnt #(
    parameter int LIMIT = 512
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic inc,
    output logic done
);

    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LIM = W'(LIMIT);

    logic [W-1:0] cnt_q;

    // clear wins; holds at the limit so done stays until cleared
    always_ff @(posedge clk)
    begin
        if (!rst_n || clr)
            cnt_q <= '0;
        else if (inc && cnt_q != LIM)
            cnt_q <= cnt_q + W'(1);
    end

    assign done = (cnt_q == LIM);

endmodule

/* tb/bho_ctrl_properties.sv */
`timescale 1ns/1ps

// ********
// port properties of the controller
// ********
module bho_ctrl_properties
    import bho_pkg::*;
#(
    parameter int HICCUP_WAIT = HICCUP_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CYCLE_START,
    input wire logic [15:0] TON_REQ_CYC,
    input wire logic CURRENT_SENSE_POS_TRIP,
    input wire logic FEEDBACK_SENSE_ABOVE_0V4,
    input wire logic [1:0] FB_RDET,
    input wire logic COMP_SELECT_PIN_PULLUP,
    input wire logic HIGH_SIDE_GATE_OUT,
    input wire logic LOW_SIDE_GATE_OUT,
    input wire logic SS_PULL_LOW,
    input wire logic PULSE_SKIP,
    input wire logic [1:0] VOUT_SEL,
    input wire logic INT_COMP
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic arm_q;
    logic fb_q;
    logic [15:0] wait_q;
    // hiccup wait in periods; armed only by a real entry, not by the reset level
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            arm_q <= 1'b0;
            fb_q <= 1'b0;
            wait_q <= 16'h0;
        end
        else
        begin
            arm_q <= SS_PULL_LOW && (arm_q || !$past(SS_PULL_LOW));
            fb_q <= !SS_PULL_LOW && (fb_q || FEEDBACK_SENSE_ABOVE_0V4);
            wait_q <= arm_q ? wait_q + 16'(CYCLE_START) : 16'h0;
        end
    end
    sequence s_hic_exit;
        arm_q && !SS_PULL_LOW;
    endsequence
    property p_trip_cut;
        CURRENT_SENSE_POS_TRIP |=> !HIGH_SIDE_GATE_OUT;
    endproperty
    a_trip_cut: assert property (p_trip_cut) else $error("high side on after trip");
    property p_vout_map;
        $rose(RST_N) |=> VOUT_SEL == $past(FB_RDET);
    endproperty
    a_vout_map: assert property (p_vout_map) else $error("setpoint not latched");
    property p_comp_map;
        $rose(RST_N) |=> INT_COMP == $past(COMP_SELECT_PIN_PULLUP);
    endproperty
    a_comp_map: assert property (p_comp_map) else $error("compensation not latched");
    property p_cfg_hold;
        $past(RST_N, 2) |-> $stable(VOUT_SEL) && $stable(INT_COMP);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");
    property p_hic_gates;
        SS_PULL_LOW |-> !HIGH_SIDE_GATE_OUT && !LOW_SIDE_GATE_OUT;
    endproperty
    a_hic_gates: assert property (p_hic_gates) else $error("gate on in hiccup");
    property p_hic_rel;
        s_hic_exit |-> wait_q >= HICCUP_WAIT - 1 && wait_q <= HICCUP_WAIT + 1;
    endproperty
    a_hic_rel: assert property (p_hic_rel) else $error("hiccup wait wrong");
    property p_hic_bound;
        arm_q |-> wait_q <= HICCUP_WAIT + 1;
    endproperty
    a_hic_bound: assert property (p_hic_bound) else $error("hiccup never ends");
    property p_skip;
        $rose(PULSE_SKIP) |-> $past(TON_REQ_CYC) < 16'(TON_MIN_CYC);
    endproperty
    a_skip: assert property (p_skip) else $error("skip without short on-time");
    property p_fb_arm;
        $rose(SS_PULL_LOW) |-> fb_q;
    endproperty
    a_fb_arm: assert property (p_fb_arm) else $error("hiccup in soft start");
endmodule

/* tb/bho_stage_model.sv */
`timescale 1ns/1ps

// ********
// power stage and sense comparator
// ********
module bho_stage_model (
    input wire logic clk,
    input wire logic high_side,
    input wire logic overload,
    output logic trip
);
    // current ramps only while the high side conducts, so trip follows it
    always_ff @(posedge clk)
    begin
        trip <= overload && high_side;
    end
endmodule

/* tb/bho_ctrl_tb_top.sv */
`timescale 1ns/1ps

module bho_ctrl_tb_top
    import bho_pkg::*;
;
    localparam int HW = 8;
    localparam int OL = 20;
    localparam int PER = 8;
    logic REF_CLK, RST_N = 0, CYCLE_START = 0, FEEDBACK_SENSE_ABOVE_0V4 = 0, COMP_SELECT_PIN_PULLUP = 0;
    logic HIGH_SIDE_GATE_OUT, LOW_SIDE_GATE_OUT, SS_PULL_LOW, SS_CLAMP_EN, PULSE_SKIP, INT_COMP, IRQ;
    logic CURRENT_SENSE_POS_TRIP, WB_ACK_O, overload = 0;
    logic [1:0] FB_RDET = 2'h0, VOUT_SEL;
    logic [15:0] TON_REQ_CYC = 16'h8;
    logic [31:0] WB_DAT_O, d;
    logic [3:0] per_q = 4'h0;
    bho_wb_req_t wb = '0;
    int fail_count = 0, cmp_count = 0;
    bho_ctrl #(.HICCUP_WAIT(HW), .OVL_LIMIT(OL)) uut (.REF_CLK, .RST_N, .CYCLE_START, .PWM_REQ(1'b1),
        .TON_REQ_CYC, .CURRENT_SENSE_POS_TRIP, .FEEDBACK_SENSE_ABOVE_0V4, .FB_RDET, .COMP_SELECT_PIN_PULLUP,
        .HIGH_SIDE_GATE_OUT, .LOW_SIDE_GATE_OUT, .SS_PULL_LOW, .SS_CLAMP_EN, .PULSE_SKIP, .VOUT_SEL,
        .INT_COMP, .IRQ, .WB_CYC_I(wb.cyc), .WB_STB_I(wb.stb), .WB_WE_I(wb.we), .WB_SEL_I(wb.sel),
        .WB_ADR_I(wb.adr), .WB_DAT_I(wb.dat), .WB_DAT_O, .WB_ACK_O);
    bho_stage_model u_stage (.clk(REF_CLK), .high_side(HIGH_SIDE_GATE_OUT), .overload,
        .trip(CURRENT_SENSE_POS_TRIP));
    initial
    begin
        REF_CLK = 0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    // oscillator stand-in: one start pulse per period
    always @(posedge REF_CLK)
    begin
        per_q <= (per_q == 4'(PER - 1)) ? 4'h0 : per_q + 4'h1;
        CYCLE_START <= (per_q == 4'(PER - 1));
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // classic single cycle; holds the request until ack is sampled, only the watchdog ends a hang
    task automatic wbx(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
        @(posedge REF_CLK);
        while (WB_ACK_O !== 1'b1)
        begin
            n++;
            @(posedge REF_CLK);
        end
        chk(32'(n), 1, "ack latency");
        d = WB_DAT_O;
        wb <= '0;
        @(posedge REF_CLK);
    endtask
    task automatic per(input int n);
        repeat (n * PER) @(posedge REF_CLK);
    endtask
    task automatic t_cfg();
        for (int i = 0; i < 4; i++)
        begin
            FB_RDET <= 2'(i);
            COMP_SELECT_PIN_PULLUP <= i[0];
            RST_N <= 1'b0;
            repeat (10) @(posedge REF_CLK);
            RST_N <= 1'b1;
            @(posedge REF_CLK);
            FB_RDET <= ~2'(i);
            COMP_SELECT_PIN_PULLUP <= ~i[0];
            per(1);
            wbx(1'b0, ADDR_CFG, 32'h0);
            chk(d, {29'h0, i[0], 2'(i)}, "cfg reg");
            chk(32'(VOUT_SEL), 32'(i), "vout");
            chk(32'(INT_COMP), 32'(i[0]), "comp");
        end
        wbx(1'b0, ADDR_CTRL, 32'h0);
        chk(d, CTRL_RESET, "ctrl reset");
        wbx(1'b1, 8'h20, 32'hFFFF_FFFF);
        wbx(1'b0, 8'h20, 32'h0);
        chk(d, 0, "unmapped");
        $display("test cfg done");
    endtask
    task automatic t_skip();
        TON_REQ_CYC <= 16'(TON_MIN_CYC - 1);
        per(3);
        chk(32'(PULSE_SKIP), 1, "skip below min");
        TON_REQ_CYC <= 16'(TON_MIN_CYC);
        per(3);
        chk(32'(PULSE_SKIP), 0, "skip at min");
        TON_REQ_CYC <= 16'h8;
        $display("test skip done");
    endtask
    // overload in soft start with irq masked, then unmasked and cleared
    task automatic t_irq_fb();
        wbx(1'b1, ADDR_MASK, 32'h0);
        overload <= 1'b1;
        per(OL + 4);
        chk(32'(SS_PULL_LOW), 0, "hiccup in soft start");
        overload <= 1'b0;
        per(5);
        chk(32'(IRQ), 0, "masked irq");
        // a set mask bit lets its status bit through to the pin
        wbx(1'b1, ADDR_MASK, 32'h7);
        chk(32'(IRQ), 1, "unmasked irq");
        wbx(1'b0, ADDR_IRQ, 32'h0);
        chk(32'(d[IRQ_OC_BIT]), 1, "oc status");
        @(posedge REF_CLK);
        chk(32'(IRQ), 0, "irq after read");
        $display("test irq done");
    endtask
    task automatic t_clean();
        FEEDBACK_SENSE_ABOVE_0V4 <= 1'b1;
        overload <= 1'b1;
        per(12);
        overload <= 1'b0;
        per(5);
        overload <= 1'b1;
        per(12);
        chk(32'(SS_PULL_LOW), 0, "overload not reset");
        overload <= 1'b0;
        per(5);
        $display("test clean done");
    endtask
    task automatic t_hic();
        int n;
        n = 0;
        overload <= 1'b1;
        per(14);
        chk(32'(SS_CLAMP_EN), 0, "early clamp");
        per(4);
        chk(32'(SS_CLAMP_EN), 1, "clamp");
        chk(32'(SS_PULL_LOW), 0, "early hiccup");
        // entry is tied to a period end, so timing from it is free of the oscillator phase
        while (SS_PULL_LOW !== 1'b1 && n < 6 * PER)
        begin
            n++;
            @(posedge REF_CLK);
        end
        chk(32'(SS_PULL_LOW), 1, "no hiccup");
        chk(32'(HIGH_SIDE_GATE_OUT), 0, "gate in hiccup");
        chk(32'(LOW_SIDE_GATE_OUT), 0, "low gate in hiccup");
        overload <= 1'b0;
        per(HW - 1);
        chk(32'(SS_PULL_LOW), 1, "early restart");
        per(2);
        chk(32'(SS_PULL_LOW), 0, "no restart");
        wbx(1'b0, ADDR_IRQ, 32'h0);
        chk(32'(d[IRQ_HIC_BIT]), 1, "hiccup status");
        $display("test hiccup done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        t_cfg();
        t_skip();
        t_irq_fb();
        t_clean();
        t_hic();
        give_verdict();
    end
    // the whole sequence takes well under a tenth of this
    initial
    begin
        #200_000;
        fail_count++;
        give_verdict();
    end
endmodule

bind bho_ctrl bho_ctrl_properties #(.HICCUP_WAIT(HICCUP_WAIT)) u_props (.REF_CLK, .RST_N, .CYCLE_START,
    .TON_REQ_CYC, .CURRENT_SENSE_POS_TRIP, .FEEDBACK_SENSE_ABOVE_0V4, .FB_RDET, .COMP_SELECT_PIN_PULLUP,
    .HIGH_SIDE_GATE_OUT, .LOW_SIDE_GATE_OUT, .SS_PULL_LOW, .PULSE_SKIP, .VOUT_SEL, .INT_COMP);
